// File: inc/sensor_pkg.sv
// shared constants for the measurement output read path
package sensor_pkg;

  localparam int WORD_W = 16;
  localparam int DATA_W = 14;
  localparam int ADDR_W = 6;
  localparam int IDX_W = 5;
  localparam int CH_W = 3;
  localparam int N_OUT = 7;
  localparam int N_WORDS = 32;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hf;

  // request word layout
  localparam int REQ_WRITE_BIT = 15;
  localparam int REQ_ADDR_MSB = 13;
  localparam int REQ_ADDR_LSB = 8;
  localparam int REQ_DATA_MSB = 7;

  // response word layout
  localparam int RESP_FRESH_BIT = 15;
  localparam int RESP_ALARM_BIT = 14;
  localparam logic [WORD_W-1:0] NO_DATA_WORD = 16'h0000;

  // output result offsets (even byte of each word)
  localparam logic [ADDR_W-1:0] SUPPLY_VOLTAGE_RESULT_OFS = 6'h02;
  localparam logic [ADDR_W-1:0] X_ACCEL_RESULT_OFS = 6'h04;
  localparam logic [ADDR_W-1:0] Y_ACCEL_RESULT_OFS = 6'h06;
  localparam logic [ADDR_W-1:0] AUX_ANALOG_INPUT_RESULT_OFS = 6'h08;
  localparam logic [ADDR_W-1:0] DIE_TEMPERATURE_RESULT_OFS = 6'h0a;
  localparam logic [ADDR_W-1:0] X_TILT_RESULT_OFS = 6'h0c;
  localparam logic [ADDR_W-1:0] Y_TILT_RESULT_OFS = 6'h0e;

  // calibration, alarm, aux line and command offsets
  localparam logic [ADDR_W-1:0] X_ACCEL_OFFSET_OFS = 6'h10;
  localparam logic [ADDR_W-1:0] Y_ACCEL_OFFSET_OFS = 6'h12;
  localparam logic [ADDR_W-1:0] X_ACCEL_SCALE_OFS = 6'h14;
  localparam logic [ADDR_W-1:0] Y_ACCEL_SCALE_OFS = 6'h16;
  localparam logic [ADDR_W-1:0] X_TILT_OFFSET_OFS = 6'h18;
  localparam logic [ADDR_W-1:0] Y_TILT_OFFSET_OFS = 6'h1a;
  localparam logic [ADDR_W-1:0] X_TILT_SCALE_OFS = 6'h1c;
  localparam logic [ADDR_W-1:0] Y_TILT_SCALE_OFS = 6'h1e;
  localparam logic [ADDR_W-1:0] ALARM1_LEVEL_OFS = 6'h20;
  localparam logic [ADDR_W-1:0] ALARM_CTRL_OFS = 6'h28;
  localparam logic [ADDR_W-1:0] AUX_LINE_CTRL_OFS = 6'h32;
  localparam logic [ADDR_W-1:0] COMMAND_OFS = 6'h3e;
  localparam logic [ADDR_W-1:0] CAL_LAST_OFS = 6'h1e;

  // channels in conversion order; channel c lives at word c+1
  localparam logic [CH_W-1:0] CH_SUPPLY = 3'h0;
  localparam logic [CH_W-1:0] CH_X_ACCEL = 3'h1;
  localparam logic [CH_W-1:0] CH_Y_ACCEL = 3'h2;
  localparam logic [CH_W-1:0] CH_X_TILT = 3'h5;
  localparam logic [CH_W-1:0] CH_Y_TILT = 3'h6;
  localparam logic [CH_W-1:0] CH_LAST = 3'h6;
  localparam logic [CH_W-1:0] CH_NONE = 3'h7;

  // calibration
  localparam logic [WORD_W-1:0] UNITY_SCALE = 16'h0800;
  localparam logic [WORD_W-1:0] ZERO_OFFSET = 16'h0000;
  localparam int SCALE_SHIFT = 11;
  localparam int NARROW_W = 12;
  localparam real ACCEL_LSB_MG = 0.4625;

  // alarm control fields, one byte per alarm
  localparam int ALM_SRC_LSB = 0;
  localparam int ALM_RATE_BIT = 3;
  localparam int ALM_EN_BIT = 4;
  localparam int ALM_STRIDE = 8;
  localparam int N_ALARM = 2;

  // aux line control: two bits per line, input levels read back at bits 9:8
  localparam logic [1:0] AUX_FN_INPUT = 2'h0;
  localparam logic [1:0] AUX_FN_READY = 2'h1;
  localparam logic [1:0] AUX_FN_ALARM = 2'h2;
  localparam int AUX_IN_LSB = 8;
  localparam int N_AUX = 2;

  // command byte bits
  localparam int CMD_NULL_BIT = 0;
  localparam int CMD_FACTORY_BIT = 1;

  localparam logic [WORD_W-1:0] CFG_RESET = 16'h0000;

endpackage

// File: src/result_cal.sv
// offset and scale correction of one raw sample
`timescale 1ns/100ps
module result_cal (
  // sample and factors
  input wire logic [sensor_pkg::DATA_W-1:0] i_raw,
  input wire logic [sensor_pkg::WORD_W-1:0] i_offset,
  input wire logic [sensor_pkg::WORD_W-1:0] i_scale,
  input wire logic i_enable,
  // corrected result
  output logic [sensor_pkg::DATA_W-1:0] o_result
);
  import sensor_pkg::*;

  logic signed [DATA_W+WORD_W-1:0] prod;
  logic signed [DATA_W+WORD_W-1:0] scaled;
  logic [DATA_W-1:0] corrected;

  assign prod = $signed(i_raw) * $signed(i_scale);
  assign scaled = prod >>> SCALE_SHIFT;
  assign corrected = scaled[DATA_W-1:0] + i_offset[DATA_W-1:0];
  // uncorrected channels keep twelve bits, top two read zero
  assign o_result = i_enable ? corrected : {{(DATA_W-NARROW_W){1'b0}}, i_raw[NARROW_W-1:0]};
endmodule

// File: src/sensor_output_register_read.sv
// measurement output registers, conversion sequencing and serial read path
`timescale 1ns/100ps
// How it works
// - one read spans two framed 16-bit frames
// - address from frame one, data in frame two
// - address sits in request bits 13:8
// - answer: fresh flag, alarm flag, data
// - fresh flag set by each new sample
// - reading clears fresh flag until next update
// - acceleration and tilt results fourteen-bit two's complement
// - other three results are twelve-bit
// - odd byte upper, even byte lower
// - either byte address returns whole word
// - seven results decoded at 0x02 to 0x0f
// - conversion sequence repeats without pause
// - same fresh behaviour in all seven
// - aux line may signal data ready
// - two alarms, threshold or rate, any source
// - alarm flag carried in every result answer
// - aux line may signal alarm
// - offset and scale on accel and tilt
// - null and factory restore commands
// - sample on rising, drive on falling
// - frame two also carries next request
// - top bit one means write, no data
module sensor_output_register_read (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  // serial link
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  // converter
  output logic o_conv_start,
  output logic [sensor_pkg::CH_W-1:0] o_conv_ch,
  input wire logic i_conv_done,
  input wire logic [sensor_pkg::DATA_W-1:0] i_conv_data,
  // aux digital lines
  input wire logic [sensor_pkg::N_AUX-1:0] i_aux_in,
  output logic [sensor_pkg::N_AUX-1:0] o_aux_out,
  output logic [sensor_pkg::N_AUX-1:0] o_aux_oe
);
  import sensor_pkg::*;

  typedef enum logic [0:0] {SEQ_START, SEQ_WAIT} seq_state_type;

  localparam logic [IDX_W-1:0] FIRST_OUT_IDX = SUPPLY_VOLTAGE_RESULT_OFS[ADDR_W-1:1];
  localparam logic [IDX_W-1:0] LAST_OUT_IDX = Y_TILT_RESULT_OFS[ADDR_W-1:1];
  localparam logic [IDX_W-1:0] CFG_FIRST_IDX = X_ACCEL_OFFSET_OFS[ADDR_W-1:1];
  localparam logic [IDX_W-1:0] CAL_LAST_IDX = CAL_LAST_OFS[ADDR_W-1:1];
  localparam logic [IDX_W-1:0] ALM_LEVEL_IDX = ALARM1_LEVEL_OFS[ADDR_W-1:1];
  localparam logic [IDX_W-1:0] ALM_CTRL_IDX = ALARM_CTRL_OFS[ADDR_W-1:1];
  localparam logic [IDX_W-1:0] AUX_CTRL_IDX = AUX_LINE_CTRL_OFS[ADDR_W-1:1];
  localparam logic [IDX_W-1:0] CMD_IDX = COMMAND_OFS[ADDR_W-1:1];

  // scale words reset to unity scale, everything else to zero
  function automatic logic [WORD_W-1:0] cfg_default(input logic [IDX_W-1:0] w);
    if (w == X_ACCEL_SCALE_OFS[ADDR_W-1:1] || w == Y_ACCEL_SCALE_OFS[ADDR_W-1:1] ||
        w == X_TILT_SCALE_OFS[ADDR_W-1:1] || w == Y_TILT_SCALE_OFS[ADDR_W-1:1]) begin
      return UNITY_SCALE;
    end
    return ZERO_OFFSET;
  endfunction

  // channel whose output an offset word nulls
  function automatic logic [CH_W-1:0] null_ch(input logic [IDX_W-1:0] w);
    if (w == X_ACCEL_OFFSET_OFS[ADDR_W-1:1]) return CH_X_ACCEL;
    if (w == Y_ACCEL_OFFSET_OFS[ADDR_W-1:1]) return CH_Y_ACCEL;
    if (w == X_TILT_OFFSET_OFS[ADDR_W-1:1]) return CH_X_TILT;
    if (w == Y_TILT_OFFSET_OFS[ADDR_W-1:1]) return CH_Y_TILT;
    return CH_NONE;
  endfunction

  logic [WORD_W-1:0] rx_word;
  logic rx_tgl;
  logic tgl_s1_ff;
  logic tgl_s2_ff;
  logic tgl_s3_ff;
  logic [WORD_W-1:0] tx_word_ff;
  logic [N_AUX-1:0] aux_s1_ff;
  logic [N_AUX-1:0] aux_s2_ff;

  seq_state_type state_ff;
  logic [CH_W-1:0] ch_ff;
  logic start_ff;
  logic pass_done_ff;
  logic ready_ff;

  logic [DATA_W-1:0] data_ff [N_OUT];
  logic fresh_ff [N_OUT];
  logic [WORD_W-1:0] cfg_ff [N_WORDS];
  logic alarm_ff [N_ALARM];
  logic [DATA_W-1:0] prev_ff [N_ALARM];
  logic [N_AUX-1:0] aux_out_ff;
  logic [N_AUX-1:0] aux_oe_ff;

  logic req_evt;
  logic req_write;
  logic req_upper;
  logic [IDX_W-1:0] req_idx;
  logic rd_out;
  logic [CH_W-1:0] rd_ch;
  logic wr_evt;
  logic cmd_null;
  logic cmd_factory;
  logic conv_take;
  logic alarm_any;
  logic cal_en;
  logic [WORD_W-1:0] cal_off;
  logic [WORD_W-1:0] cal_scale;
  logic [DATA_W-1:0] cal_res;
  logic [WORD_W-1:0] read_word;

  spi_link u_link (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_din(i_din),
    .i_arst_n(i_arst_n),
    .o_dout(o_dout),
    .i_tx_word(tx_word_ff),
    .o_rx_word(rx_word),
    .o_rx_tgl(rx_tgl)
  );

  // frame-end toggle crosses in; the held word is read only after it
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
    end else if (i_clk_en) begin
      tgl_s1_ff <= rx_tgl;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aux_s1_ff <= '0;
      aux_s2_ff <= '0;
    end else if (i_clk_en) begin
      aux_s1_ff <= i_aux_in;
      aux_s2_ff <= aux_s1_ff;
    end
  end

  // request decode; low address bit only picks a byte for writes
  assign req_evt = tgl_s2_ff ^ tgl_s3_ff;
  assign req_write = rx_word[REQ_WRITE_BIT];
  assign req_idx = rx_word[REQ_ADDR_MSB:REQ_ADDR_LSB+1];
  assign req_upper = rx_word[REQ_ADDR_LSB];
  assign rd_out = req_evt && !req_write && req_idx >= FIRST_OUT_IDX && req_idx <= LAST_OUT_IDX;
  assign rd_ch = CH_W'(req_idx - FIRST_OUT_IDX);
  assign wr_evt = req_evt && req_write;
  assign cmd_null = wr_evt && req_idx == CMD_IDX && !req_upper && rx_word[CMD_NULL_BIT];
  assign cmd_factory = wr_evt && req_idx == CMD_IDX && !req_upper && rx_word[CMD_FACTORY_BIT];
  assign conv_take = state_ff == SEQ_WAIT && i_conv_done;

  // endless channel sequence
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= SEQ_START;
      ch_ff <= CH_SUPPLY;
      start_ff <= 1'b0;
      pass_done_ff <= 1'b0;
    end else if (i_clk_en) begin
      start_ff <= 1'b0;
      pass_done_ff <= 1'b0;
      case (state_ff)
        SEQ_START: begin
          start_ff <= 1'b1;
          state_ff <= SEQ_WAIT;
        end
        SEQ_WAIT: begin
          if (i_conv_done) begin
            state_ff <= SEQ_START;
            if (ch_ff == CH_LAST) begin
              ch_ff <= CH_SUPPLY;
              pass_done_ff <= 1'b1;
            end else begin
              ch_ff <= ch_ff + 1'b1;
            end
          end
        end
        default: state_ff <= SEQ_START;
      endcase
    end
  end

  // correction factors by channel
  always_comb begin
    cal_en = 1'b1;
    cal_off = cfg_ff[X_ACCEL_OFFSET_OFS[ADDR_W-1:1]];
    cal_scale = cfg_ff[X_ACCEL_SCALE_OFS[ADDR_W-1:1]];
    case (ch_ff)
      CH_X_ACCEL: cal_en = 1'b1;
      CH_Y_ACCEL: begin
        cal_off = cfg_ff[Y_ACCEL_OFFSET_OFS[ADDR_W-1:1]];
        cal_scale = cfg_ff[Y_ACCEL_SCALE_OFS[ADDR_W-1:1]];
      end
      CH_X_TILT: begin
        cal_off = cfg_ff[X_TILT_OFFSET_OFS[ADDR_W-1:1]];
        cal_scale = cfg_ff[X_TILT_SCALE_OFS[ADDR_W-1:1]];
      end
      CH_Y_TILT: begin
        cal_off = cfg_ff[Y_TILT_OFFSET_OFS[ADDR_W-1:1]];
        cal_scale = cfg_ff[Y_TILT_SCALE_OFS[ADDR_W-1:1]];
      end
      default: cal_en = 1'b0;
    endcase
  end

  result_cal u_cal (
    .i_raw(i_conv_data),
    .i_offset(cal_off),
    .i_scale(cal_scale),
    .i_enable(cal_en),
    .o_result(cal_res)
  );

  // output words: new sample sets flag with data, read clears, set wins
  for (genvar c = 0; c < N_OUT; c++) begin : g_out
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        data_ff[c] <= '0;
        fresh_ff[c] <= 1'b0;
      end else if (i_clk_en) begin
        if (conv_take && ch_ff == CH_W'(c)) begin
          data_ff[c] <= cal_res;
          fresh_ff[c] <= 1'b1;
        end else if (rd_out && rd_ch == CH_W'(c)) begin
          fresh_ff[c] <= 1'b0;
        end
      end
    end
  end

  // settings words, byte written; factory restore beats null beats write
  for (genvar w = 0; w < N_WORDS; w++) begin : g_cfg
    if (w >= CFG_FIRST_IDX && w != CMD_IDX) begin : g_rw
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          cfg_ff[w] <= cfg_default(IDX_W'(w));
        end else if (i_clk_en) begin
          if (cmd_factory && w <= CAL_LAST_IDX) begin
            cfg_ff[w] <= cfg_default(IDX_W'(w));
          end else if (cmd_null && null_ch(IDX_W'(w)) != CH_NONE) begin
            cfg_ff[w] <= cfg_ff[w] - {{(WORD_W-DATA_W){data_ff[null_ch(IDX_W'(w))][DATA_W-1]}},
                                      data_ff[null_ch(IDX_W'(w))]};
          end else if (wr_evt && req_idx == IDX_W'(w)) begin
            if (req_upper) begin
              cfg_ff[w][WORD_W-1:REQ_ADDR_LSB] <= rx_word[REQ_DATA_MSB:0];
            end else begin
              cfg_ff[w][REQ_DATA_MSB:0] <= rx_word[REQ_DATA_MSB:0];
            end
          end
        end
      end
    end else begin : g_ro
      assign cfg_ff[w] = CFG_RESET;
    end
  end

  // two alarms, each on a chosen source, threshold or rate of change
  for (genvar k = 0; k < N_ALARM; k++) begin : g_alarm
    logic [CH_W-1:0] src;
    logic rate;
    logic en;
    logic [DATA_W-1:0] level;
    logic signed [DATA_W:0] diff;
    logic [DATA_W:0] mag;
    assign src = cfg_ff[ALM_CTRL_IDX][k*ALM_STRIDE+ALM_SRC_LSB +: CH_W];
    assign rate = cfg_ff[ALM_CTRL_IDX][k*ALM_STRIDE+ALM_RATE_BIT];
    assign en = cfg_ff[ALM_CTRL_IDX][k*ALM_STRIDE+ALM_EN_BIT];
    assign level = cfg_ff[ALM_LEVEL_IDX+IDX_W'(k)][DATA_W-1:0];
    assign diff = $signed({cal_res[DATA_W-1], cal_res}) - $signed({prev_ff[k][DATA_W-1], prev_ff[k]});
    assign mag = diff[DATA_W] ? (DATA_W+1)'(-diff) : diff;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        alarm_ff[k] <= 1'b0;
        prev_ff[k] <= '0;
      end else if (i_clk_en) begin
        if (!en) begin
          alarm_ff[k] <= 1'b0;
        end else if (conv_take && ch_ff == src) begin
          alarm_ff[k] <= rate ? (mag > {1'b0, level}) : ($signed(cal_res) > $signed(level));
          prev_ff[k] <= cal_res;
        end
      end
    end
  end

  assign alarm_any = alarm_ff[0] | alarm_ff[1];

  // answer word for the request just taken
  always_comb begin
    read_word = cfg_ff[req_idx];
    if (rd_out) begin
      read_word = {fresh_ff[rd_ch], alarm_any, data_ff[rd_ch]};
    end else if (req_idx == AUX_CTRL_IDX) begin
      read_word[AUX_IN_LSB +: N_AUX] = aux_s2_ff;
    end
  end

  // loaded between frames, shifted out in the next frame
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_word_ff <= NO_DATA_WORD;
    end else if (i_clk_en && req_evt) begin
      tx_word_ff <= req_write ? NO_DATA_WORD : read_word;
    end
  end

  // ready level: pass end sets, output read clears, set wins
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ready_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (pass_done_ff) begin
        ready_ff <= 1'b1;
      end else if (rd_out) begin
        ready_ff <= 1'b0;
      end
    end
  end

  for (genvar l = 0; l < N_AUX; l++) begin : g_aux
    logic [1:0] fn;
    assign fn = cfg_ff[AUX_CTRL_IDX][2*l +: 2];
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        aux_out_ff[l] <= 1'b0;
        aux_oe_ff[l] <= 1'b0;
      end else if (i_clk_en) begin
        aux_out_ff[l] <= (fn == AUX_FN_READY && ready_ff) || (fn == AUX_FN_ALARM && alarm_any);
        aux_oe_ff[l] <= fn == AUX_FN_READY || fn == AUX_FN_ALARM;
      end
    end
  end

  assign o_conv_start = start_ff;
  assign o_conv_ch = ch_ff;
  assign o_aux_out = aux_out_ff;
  assign o_aux_oe = aux_oe_ff;

  default clocking cb @(posedge i_ref_clk iff i_clk_en);
  endclocking
  default disable iff (!i_arst_n);

  chk_fresh_on_sample: assert property (conv_take |=> fresh_ff[$past(ch_ff)])
    else $error("fresh flag not set by new sample");
  chk_read_clears_flag: assert property ((rd_out && !(conv_take && ch_ff == rd_ch)) |=> !fresh_ff[$past(rd_ch)])
    else $error("read did not clear fresh flag");
  chk_answer_word: assert property (rd_out |=> tx_word_ff[DATA_W-1:0] == $past(data_ff[rd_ch]) &&
      tx_word_ff[RESP_FRESH_BIT] == $past(fresh_ff[rd_ch]))
    else $error("answer word disagrees with stored result");
  chk_alarm_in_answer: assert property (rd_out |=> tx_word_ff[RESP_ALARM_BIT] == $past(alarm_any))
    else $error("alarm bit missing from answer");
  chk_write_no_data: assert property (wr_evt |=> tx_word_ff == NO_DATA_WORD)
    else $error("write request produced read data");
  chk_seq_wraps: assert property ((conv_take && ch_ff == CH_LAST) |=> ch_ff == CH_SUPPLY && pass_done_ff ##1 start_ff)
    else $error("sequence did not wrap and restart");
  chk_ready_line: assert property ((pass_done_ff && g_aux[0].fn == AUX_FN_READY) |=> ##1 o_aux_out[0] && o_aux_oe[0])
    else $error("ready not shown on aux line");
  chk_factory_scale: assert property (cmd_factory |=> cfg_ff[X_ACCEL_SCALE_OFS[ADDR_W-1:1]] == UNITY_SCALE)
    else $error("factory restore left scale changed");
  chk_start_pulse: assert property (start_ff |=> !start_ff [*2])
    else $error("conversion start longer than one cycle");
endmodule

// File: src/spi_link.sv
// serial shifter on the link clock, frame capture and response shift-out
`timescale 1ns/100ps
module spi_link (
  // link pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic i_arst_n,
  output logic o_dout,
  // core side
  input wire logic [sensor_pkg::WORD_W-1:0] i_tx_word,
  output logic [sensor_pkg::WORD_W-1:0] o_rx_word,
  output logic o_rx_tgl
);
  import sensor_pkg::*;

  logic [BIT_CNT_W-1:0] bit_cnt_ff;
  logic [WORD_W-2:0] rx_sh_ff;
  logic [WORD_W-2:0] tx_sh_ff;
  logic [WORD_W-1:0] rx_word_ff;
  logic rx_tgl_ff;
  logic dout_ff;

  // deselect clears the frame position
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_cnt_ff <= '0;
      rx_sh_ff <= '0;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
      rx_sh_ff <= {rx_sh_ff[WORD_W-3:0], i_din};
    end
  end

  // whole word only after the sixteenth rising edge
  always_ff @(posedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_word_ff <= '0;
      rx_tgl_ff <= 1'b0;
    end else if (!i_cs_n && bit_cnt_ff == LAST_BIT) begin
      rx_word_ff <= {rx_sh_ff, i_din};
      rx_tgl_ff <= ~rx_tgl_ff;
    end
  end

  // msb leaves on the first falling edge of the frame
  always_ff @(negedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dout_ff <= 1'b0;
      tx_sh_ff <= '0;
    end else if (bit_cnt_ff == '0) begin
      {dout_ff, tx_sh_ff} <= i_tx_word;
    end else begin
      {dout_ff, tx_sh_ff} <= {tx_sh_ff, 1'b0};
    end
  end

  assign o_dout = dout_ff;
  assign o_rx_word = rx_word_ff;
  assign o_rx_tgl = rx_tgl_ff;
endmodule

// File: tb/spi_host_model.sv
// serial master model: mode 3 frames, msb first, select held per frame
`timescale 1ns/100ps
module spi_host_model (
  // link pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  input wire logic i_dout,
  // bench side
  output logic [15:0] o_resp,
  output logic o_done
);
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din = 1'b0;
    o_resp = 16'h0000;
    o_done = 1'b0;
  end

  // one whole 16-bit frame; clock stands high outside it
  task automatic xfer(input logic [15:0] req);
    logic [15:0] got;
    got = 16'h0000;
    o_cs_n = 1'b0;
    #32;
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_din = req[i];
      #32;
      o_sclk = 1'b1;
      got = {got[14:0], i_dout};
      #32;
    end
    o_cs_n = 1'b1;
    // released line shows no stale level
    o_din = ~req[0];
    o_resp = got;
    o_done = 1'b1;
    #1;
    o_done = 1'b0;
    // select high long enough for the answer to load
    #400;
  endtask
endmodule

// File: tb/testbench.sv
// bench: host frames, converter model, queued answer checks
`timescale 1ns/100ps
module testbench;
  import sensor_pkg::*;
  logic i_ref_clk, i_arst_n, i_conv_done, sclk, cs_n, din, dout, done, conv_start, clk_en, alm;
  logic [N_AUX-1:0] aux_out, aux_oe;
  logic [DATA_W-1:0] i_conv_data;
  logic [CH_W-1:0] conv_ch, exp_ch;
  logic [WORD_W-1:0] resp;
  logic [DATA_W-1:0] val [N_OUT];
  logic fresh [N_OUT];
  logic [31:0] seed;
  logic [31:0] expq [$];
  int err_total, checks, budget;

  sensor_output_register_read dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(clk_en), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_din(din), .o_dout(dout), .o_conv_start(conv_start), .o_conv_ch(conv_ch),
    .i_conv_done(i_conv_done), .i_conv_data(i_conv_data), .i_aux_in(2'h0), .o_aux_out(aux_out), .o_aux_oe(aux_oe));
  spi_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout), .o_resp(resp), .o_done(done));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] seen, input logic [15:0] mask);
    checks++;
    if (((seen ^ expv) & mask) !== 16'h0000) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // frame out, then note what the next frame must return
  task automatic rd(input logic [15:0] req);
    logic [15:0] e, m;
    int c;
    @(negedge i_ref_clk);
    host.xfer(req);
    e = NO_DATA_WORD;
    m = 16'hffff;
    c = int'(req[REQ_ADDR_MSB:REQ_ADDR_LSB+1]) - 1;
    if (req[REQ_WRITE_BIT] == 1'b0 && c >= 0 && c < N_OUT) begin
      e = {fresh[c], alm, val[c]};
      fresh[c] = 1'b0;
      if (c != int'(CH_X_ACCEL) && c != int'(CH_Y_ACCEL)) begin
        m = 16'hcfff;
      end
    end
    expq.push_back({m, e});
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // converter: answers while budget lasts, else leaves device waiting
  initial begin
    i_conv_done = 1'b0;
    i_conv_data = '0;
    forever begin
      @(negedge i_ref_clk);
      if (conv_start === 1'b1) begin
        chk("conv_ch", 16'(exp_ch), 16'(conv_ch), 16'h0007);
        repeat (2) @(negedge i_ref_clk);
        while (budget == 0) @(negedge i_ref_clk);
        i_conv_data = DATA_W'(xs());
        i_conv_done = 1'b1;
        val[exp_ch] = i_conv_data;
        fresh[exp_ch] = 1'b1;
        // alarm one watches supply against a zero level
        if (exp_ch == CH_SUPPLY) begin
          alm = i_conv_data[NARROW_W-1:0] != '0;
        end
        budget--;
        @(negedge i_ref_clk);
        i_conv_done = 1'b0;
        exp_ch = (exp_ch == CH_LAST) ? CH_SUPPLY : exp_ch + 3'h1;
      end
    end
  end

  always @(posedge done) begin
    if (expq.size() > 0) begin
      chk("answer", expq[0][15:0], resp, expq[0][31:16]);
      void'(expq.pop_front());
    end
  end

  initial begin
    i_arst_n = 1'b0;
    seed = 32'h39ad;
    budget = 0;
    alm = 1'b0;
    clk_en = 1'b0;
    err_total = 0;
    checks = 0;
    exp_ch = CH_SUPPLY;
    for (int i = 0; i < N_OUT; i++) begin
      fresh[i] = 1'b0;
      val[i] = '0;
    end
    // first frame answers nothing known
    expq.push_back(32'h0);
    repeat (3) @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    // enable held low keeps the sequencer from starting
    repeat (3) begin
      @(negedge i_ref_clk);
      chk("frozen_start", 16'h0000, 16'(conv_start), 16'h0001);
    end
    clk_en = 1'b1;
    // aux line 0 shows data ready, alarm one on supply
    rd(16'hb201);
    rd(16'ha810);
    for (int p = 0; p < 2; p++) begin
      budget = N_OUT;
      while (budget > 0) @(negedge i_ref_clk);
      repeat (4) @(negedge i_ref_clk);
      chk("aux_ready", 16'h0005, 16'({aux_oe, aux_out}), 16'h000f);
      for (int a = 2; a < 16; a++) begin
        rd({2'b00, 6'(a), 8'(xs())});
      end
      rd(16'hbe02);
      chk("aux_cleared", 16'h0004, 16'({aux_oe, aux_out}), 16'h000f);
    end
    rd(16'h0000);
    rd(16'h0000);
    repeat (4) @(negedge i_ref_clk);
    end_of_test();
  end

  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
endmodule
